// >>> lscmc_pkg.sv
// constants for the low-side channel mode control block
package lscmc_pkg;
  localparam int LSCMC_CHANNELS = 12;
  localparam logic [1:0] LSCMC_CMD_STANDBY = 2'h0;
  localparam logic [1:0] LSCMC_CMD_ON = 2'h2;
  localparam logic [1:0] LSCMC_CMD_OFF = 2'h3;
  localparam logic [1:0] LSCMC_CMD_RESET = 2'h3;
  localparam logic LSCMC_TER_RESET = 1'h1;
  localparam logic [7:0] LSCMC_ADDR_CMD = 8'h00;
  localparam logic [7:0] LSCMC_ADDR_FAULT = 8'h04;
  localparam logic [7:0] LSCMC_ADDR_STATUS = 8'h08;
  localparam logic [7:0] LSCMC_ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] LSCMC_ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] LSCMC_ADDR_OUTPUT = 8'h14;
  localparam int LSCMC_IRQ_BITS = 4;
  localparam int LSCMC_IRQ_OVERLOAD = 0;
  localparam int LSCMC_IRQ_STANDBY = 1;
  localparam int LSCMC_IRQ_LOCKOUT = 2;
  localparam int LSCMC_IRQ_FRAME = 3;
  typedef enum logic [1:0] {
    LSCMC_ST_LOCKOUT = 2'h0,
    LSCMC_ST_SLEEP = 2'h1,
    LSCMC_ST_RUN = 2'h3
  } lscmc_state_t;
endpackage

// >>> lscmc_sync.sv
// two-stage synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
module lscmc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// >>> lscmc_top.sv
// channel mode, fault latch and power-up control for the twelve low-side drivers
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
module lscmc_top
  import lscmc_pkg::*;
#(
  parameter int CHANNELS = LSCMC_CHANNELS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic vdd_por_n,
  input wire logic vdda_por_n,
  input wire logic enable,
  input wire logic [CHANNELS-1:0] overload,
  input wire logic frame_error,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic [CHANNELS-1:0] switch_on,
  output logic [CHANNELS-1:0] diag_sink_en,
  output logic global_standby,
  output logic low_iq,
  output logic irq
);
  localparam int CW = 2 * CHANNELS;

  logic [CHANNELS+3:0] pin_sync;
  logic por_ok;
  logic en_ok;
  logic [CHANNELS-1:0] ovl_s;
  logic frame_err_s;
  logic frame_err_d;
  lscmc_state_t state;
  lscmc_state_t next_state;
  logic [CW-1:0] cmd;
  logic [CHANNELS-1:0] fault;
  logic [CHANNELS-1:0] powerup;
  logic transmission_error_flag;
  logic [LSCMC_IRQ_BITS-1:0] irq_stat;
  logic [LSCMC_IRQ_BITS-1:0] irq_mask;
  logic [LSCMC_IRQ_BITS-1:0] irq_event;
  logic run;
  logic cmd_wr;
  logic standby_seen;
  logic all_standby;
  logic [CHANNELS-1:0] ch_on;
  logic [CHANNELS-1:0] ch_diag;
  logic [CHANNELS-1:0] new_fault;

  // command field of one channel out of a packed word
  function automatic logic [1:0] ch_cmd(input logic [CW-1:0] word, input int ch);
    ch_cmd = word[2*ch +: 2];
  endfunction

  // pins from outside the clock domain
  lscmc_sync #(
    .WIDTH(CHANNELS + 4)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in({frame_error, overload, enable, vdda_por_n, vdd_por_n}),
    .sync_out(pin_sync)
  );

  assign por_ok = pin_sync[0] & pin_sync[1];
  assign en_ok = pin_sync[2];
  assign ovl_s = pin_sync[CHANNELS+2:3];
  assign frame_err_s = pin_sync[CHANNELS+3];

  always_comb begin
    case (state)
      LSCMC_ST_LOCKOUT: next_state = en_ok ? LSCMC_ST_RUN : LSCMC_ST_SLEEP;
      LSCMC_ST_SLEEP: next_state = en_ok ? LSCMC_ST_RUN : LSCMC_ST_SLEEP;
      LSCMC_ST_RUN: next_state = en_ok ? LSCMC_ST_RUN : LSCMC_ST_SLEEP;
      default: next_state = LSCMC_ST_LOCKOUT;
    endcase
    if (!por_ok) begin
      next_state = LSCMC_ST_LOCKOUT;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= LSCMC_ST_LOCKOUT;
    end else begin
      state <= next_state;
    end
  end

  assign run = (state == LSCMC_ST_RUN) && (next_state == LSCMC_ST_RUN);
  assign cmd_wr = run && wr && (addr == LSCMC_ADDR_CMD);

  always_comb begin
    standby_seen = 1'b0;
    all_standby = 1'b1;
    for (int i = 0; i < CHANNELS; i++) begin
      if (cmd_wr && ch_cmd(wdata[CW-1:0], i) == LSCMC_CMD_STANDBY) begin
        standby_seen = 1'b1;
      end
      if (ch_cmd(cmd, i) != LSCMC_CMD_STANDBY) begin
        all_standby = 1'b0;
      end
    end
  end

  // command word: all ones out of reset, lockout or sleep
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cmd <= '1;
    end else if (!run) begin
      cmd <= '1;
    end else if (cmd_wr) begin
      cmd <= wdata[CW-1:0];
    end
  end

  generate
    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
      assign new_fault[g] = ovl_s[g] && ch_cmd(cmd, g) == LSCMC_CMD_ON && !fault[g];

      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          powerup[g] <= 1'b1;
        end else if (state == LSCMC_ST_LOCKOUT) begin
          powerup[g] <= 1'b1;
        end else if (state == LSCMC_ST_SLEEP) begin
          powerup[g] <= 1'b0;
        end else if (cmd_wr && ch_cmd(wdata[CW-1:0], g) == LSCMC_CMD_OFF) begin
          powerup[g] <= 1'b0;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          fault[g] <= 1'b0;
        end else if (!run) begin
          fault[g] <= 1'b0;
        end else if (new_fault[g]) begin
          fault[g] <= 1'b1;
        end else if (standby_seen) begin
          fault[g] <= 1'b0;
        end
      end

      always_comb begin
        ch_on[g] = run && !all_standby && ch_cmd(cmd, g) == LSCMC_CMD_ON
          && !fault[g] && !ovl_s[g];
        ch_diag[g] = run && !all_standby && ch_cmd(cmd, g) == LSCMC_CMD_OFF
          && !powerup[g];
      end
    end
  endgenerate

  // transmission error flag set out of reset, cleared by a command write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      transmission_error_flag <= LSCMC_TER_RESET;
    end else if (!run) begin
      transmission_error_flag <= LSCMC_TER_RESET;
    end else if (frame_err_s) begin
      transmission_error_flag <= 1'b1;
    end else if (cmd_wr) begin
      transmission_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      frame_err_d <= 1'b0;
    end else begin
      frame_err_d <= frame_err_s;
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[LSCMC_IRQ_OVERLOAD] = |new_fault;
    irq_event[LSCMC_IRQ_STANDBY] = standby_seen;
    irq_event[LSCMC_IRQ_LOCKOUT] = (state != LSCMC_ST_LOCKOUT) && !por_ok;
    irq_event[LSCMC_IRQ_FRAME] = frame_err_s && !frame_err_d;
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_stat <= '0;
    end else if (wr && addr == LSCMC_ADDR_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~wdata[LSCMC_IRQ_BITS-1:0]) | irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_mask <= '0;
    end else if (wr && addr == LSCMC_ADDR_IRQ_MASK) begin
      irq_mask <= wdata[LSCMC_IRQ_BITS-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat | irq_event) & irq_mask);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      switch_on <= '0;
      diag_sink_en <= '0;
      global_standby <= 1'b0;
      low_iq <= 1'b1;
    end else begin
      switch_on <= ch_on;
      diag_sink_en <= ch_diag;
      global_standby <= run && all_standby;
      low_iq <= !en_ok || state != LSCMC_ST_RUN;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        LSCMC_ADDR_CMD: rdata <= 32'(cmd);
        LSCMC_ADDR_FAULT: rdata <= 32'(fault);
        LSCMC_ADDR_STATUS: rdata <= {26'h0000000, global_standby, low_iq, state, transmission_error_flag, por_ok};
        LSCMC_ADDR_IRQ_STAT: rdata <= 32'(irq_stat);
        LSCMC_ADDR_IRQ_MASK: rdata <= 32'(irq_mask);
        LSCMC_ADDR_OUTPUT: rdata <= 32'({diag_sink_en, switch_on});
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule

// >>> lscmc_host.sv
// register bus master model standing in for the host controller
`timescale 1ns/1ps
module lscmc_host (
  input wire logic ref_clk,
  input wire logic [31:0] rdata,
  output logic [7:0] addr = 8'h00,
  output logic [31:0] wdata = 32'h0,
  output logic wr = 1'b0,
  output logic rd = 1'b0
);
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule

// >>> lscmc_top_props.sv
// port assertions for the channel mode control block
`timescale 1ns/1ps
module lscmc_top_props #(
  parameter int CHANNELS = 12
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic vdd_por_n,
  input wire logic vdda_por_n,
  input wire logic enable,
  input wire logic [CHANNELS-1:0] overload,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [CHANNELS-1:0] switch_on,
  input wire logic [CHANNELS-1:0] diag_sink_en,
  input wire logic global_standby,
  input wire logic low_iq,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rst;
    disable iff (1'b0) !rst_n |=> !switch_on && !diag_sink_en && low_iq && !irq;
  endproperty
  property p_off; (switch_on & diag_sink_en) == '0; endproperty
  property p_gs; global_standby |-> !switch_on && !diag_sink_en; endproperty
  property p_sleep; !enable [*4] |=> low_iq && !switch_on; endproperty
  property p_por; (!vdd_por_n || !vdda_por_n) [*4] |=> low_iq && !switch_on; endproperty
  property p_ovl; overload[0] [*5] |=> !switch_on[0]; endproperty
  property p_on; $rose(switch_on[0]) |-> $past(wr, 2); endproperty
  property p_rd; !$past(rd) |-> rdata == '0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle in reset");
  a_off: assert property (p_off) else $error("driver and sink both on");
  a_gs: assert property (p_gs) else $error("active in global standby");
  a_sleep: assert property (p_sleep) else $error("active with enable low");
  a_por: assert property (p_por) else $error("active in supply lockout");
  a_ovl: assert property (p_ovl) else $error("overload did not switch off");
  a_on: assert property (p_on) else $error("turn-on without command");
  a_rd: assert property (p_rd) else $error("read data outside slot");
  c_gs: cover property (global_standby);
  c_irq: cover property ($rose(irq));
  c_ovl: cover property (overload[0] ##6 !switch_on[0]);
endmodule
bind lscmc_top lscmc_top_props #(.CHANNELS(CHANNELS)) i_props (.ref_clk, .rst_n, .vdd_por_n,
  .vdda_por_n, .enable, .overload, .wr, .rd, .rdata, .switch_on, .diag_sink_en,
  .global_standby, .low_iq, .irq);

// >>> testbench.sv
// self-checking bench for the channel mode control block
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0, rst_n = 1'b0;
  logic vdd_por_n = 1'b1, vdda_por_n = 1'b1, enable = 1'b1;
  logic [11:0] overload = 12'h000;
  logic frame_error = 1'b0;
  logic wr, rd, global_standby, low_iq, irq;
  logic [11:0] switch_on, diag_sink_en;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  int error_cnt = 0;
  int samples_checked = 0;
  lscmc_top i_dut (.ref_clk, .rst_n, .vdd_por_n, .vdda_por_n, .enable, .overload,
    .frame_error, .addr, .wdata, .wr, .rd, .rdata, .switch_on, .diag_sink_en,
    .global_standby, .low_iq, .irq);
  lscmc_host i_host (.ref_clk, .rdata, .addr, .wdata, .wr, .rd);
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    i_host.rd_reg(a, v);
    chk(v, exp);
  endtask
  task automatic wcmd(input logic [31:0] d);
    i_host.wr_reg(8'h00, d);
    cyc(3);
  endtask
  task automatic t_pu;
    rchk(8'h00, 32'h00FFFFFF);
    rchk(8'h08, 32'h0000000F);
    chk({diag_sink_en, switch_on}, 32'h0);
    $display("power-up test end");
  endtask
  task automatic t_ovl;
    wcmd(32'h00FFFFFE);
    rchk(8'h14, 32'h00FFE001);
    i_host.wr_reg(8'h10, 32'h0);
    overload <= 12'h001;
    cyc(6);
    chk({irq, diag_sink_en, switch_on}, 32'h0FFE000);
    rchk(8'h04, 32'h1);
    i_host.wr_reg(8'h10, 32'hF);
    overload <= 12'h000;
    cyc(6);
    chk({irq, diag_sink_en, switch_on}, 32'h1FFE000);
    i_host.wr_reg(8'h0C, 32'hF);
    rchk(8'h0C, 32'h0);
    wcmd(32'h003FFFFE);
    rchk(8'h04, 32'h0);
    rchk(8'h0C, 32'h2);
    chk({diag_sink_en, switch_on}, 32'h7FE001);
    $display("overload test end");
  endtask
  task automatic t_gs;
    wcmd(32'h0);
    chk({global_standby, diag_sink_en, switch_on}, 32'h1000000);
    rchk(8'h08, 32'h0000002D);
    @(posedge ref_clk);
    frame_error <= 1'b1;
    cyc(4);
    @(posedge ref_clk);
    frame_error <= 1'b0;
    cyc(3);
    rchk(8'h08, 32'h0000002F);
    rchk(8'h0C, 32'h0000000A);
    $display("standby test end");
  endtask
  task automatic t_sleep;
    @(posedge ref_clk);
    enable <= 1'b0;
    cyc(5);
    chk({low_iq, switch_on}, 32'h1000);
    @(posedge ref_clk);
    enable <= 1'b1;
    cyc(6);
    rchk(8'h00, 32'h00FFFFFF);
    chk({diag_sink_en, switch_on}, 32'hFFF000);
    $display("sleep test end");
  endtask
  task automatic t_por;
    wcmd(32'h00FFFFFE);
    @(posedge ref_clk);
    vdda_por_n <= 1'b0;
    cyc(5);
    chk({low_iq, diag_sink_en, switch_on}, 32'h1000000);
    @(posedge ref_clk);
    vdda_por_n <= 1'b1;
    cyc(6);
    t_pu;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(6);
    t_pu;
    t_ovl;
    t_gs;
    t_sleep;
    t_por;
    finish_test;
  end
endmodule
